//--- oad_pkg.sv
// Constants and types shared by the operand address decoder.
package oad_pkg;
  // Clocks per state time.
  localparam int STATE_CLKS = 2;
  // Boundary between on-chip RAM and SFR space for direct bytes.
  localparam logic [7:0] SFR_BASE = 8'h80;
  // First byte of the legacy bit-addressable RAM area.
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  // Lowest RAM byte reachable by the extended bit form.
  localparam logic [7:0] EXT_BIT_LOW = 8'h20;
  // Region zero prefix of a linear address.
  localparam logic [7:0] REGION_ZERO = 8'h00;
  // Highest ordinary word and dword register indices.
  localparam logic [5:0] WORD_MAX = 6'h1e;
  localparam logic [5:0] DWORD_MAX = 6'h1c;
  // The two extra dword pointers above the ordinary range.
  localparam logic [5:0] DWORD_ALT0 = 6'h38;
  localparam logic [5:0] DWORD_ALT1 = 6'h3c;
  // Short immediate values by code.
  localparam logic [31:0] SHORT_ONE = 32'h0000_0001;
  localparam logic [31:0] SHORT_TWO = 32'h0000_0002;
  localparam logic [31:0] SHORT_FOUR = 32'h0000_0004;
  // Bit number field of the extended bit form.
  localparam int EXT_BIT_LSB = 8;

  // Operand notation presented with a request.
  typedef enum logic [4:0] {
    FORM_DIRECT_BYTE, FORM_DIRECT_WIDE, FORM_IMM8, FORM_IMMEDIATE_WORD,
    FORM_IMM_ZERO_EXT, FORM_IMM_ONE_EXT, FORM_SHORT, FORM_LEGACY_BIT,
    FORM_EXT_BIT, FORM_REL, FORM_BLOCK_JUMP, FORM_REGION_JUMP,
    FORM_LINEAR_JUMP, FORM_LEGACY_IND, FORM_BANK_BYTE, FORM_FILE_BYTE,
    FORM_WORD_REG, FORM_WORD_IND, FORM_WORD_IND_DISP, FORM_DWORD_REG,
    FORM_DWORD_IND, FORM_DWORD_IND_DISP
  } oad_form_t;

  // Space that the resolved operand lives in.
  typedef enum logic [2:0] {
    SP_NONE, SP_RAM, SP_SFR, SP_DATA, SP_CODE, SP_REG, SP_CONST
  } oad_space_t;

  // Access width.
  typedef enum logic [1:0] {W_BYTE, W_WORD, W_DWORD} oad_width_t;

  // Request from the execution pipeline.
  typedef struct packed {
    oad_form_t form;
    logic [23:0] field;
    logic [23:0] nextPc;
    logic [31:0] ptr;
    logic [1:0] bank;
    oad_width_t peerWidth;
  } oad_req_t;

  // Register selection from the register decoder.
  typedef struct packed {
    logic [5:0] idx;
    oad_width_t width;
    logic legal;
  } oad_rsel_t;

  // Resolved operand returned to the pipeline.
  typedef struct packed {
    oad_space_t space;
    logic [23:0] addr;
    logic [31:0] value;
    logic [2:0] bitPos;
    logic bitOp;
    logic [5:0] regIdx;
    oad_width_t width;
    logic illegal;
  } oad_res_t;
endpackage

//--- oad_reg_decode.sv
// Register operand index decoder for the operand address decoder.
`timescale 1ns/1ps
`default_nettype none
module oad_reg_decode
  import oad_pkg::*;
(
  input wire oad_form_t form,
  input wire logic [23:0] field,
  input wire logic [1:0] bank,
  output oad_rsel_t sel
);
  // Register number as coded in the low field bits.
  logic [5:0] num;
  assign num = field[5:0];

  // Pure decode; the top registers the result.
  always_comb
  begin
    sel = '{idx: 6'h00, width: W_BYTE, legal: 1'b1};
    unique case (form)
      FORM_LEGACY_IND:
      begin
        // Only R0 or R1 may act as the pointer.
        sel.idx = {5'h00, field[0]};
      end
      FORM_BANK_BYTE:
      begin
        // Bank picks the group of eight, field the member.
        sel.idx = {1'b0, bank, field[2:0]};
      end
      FORM_FILE_BYTE:
      begin
        sel.idx = {2'b00, field[3:0]};
      end
      FORM_WORD_REG, FORM_WORD_IND, FORM_WORD_IND_DISP:
      begin
        // An odd or out of range word register is refused.
        sel.idx = num;
        sel.width = W_WORD;
        sel.legal = !num[0] && (num <= WORD_MAX);
      end
      FORM_DWORD_REG, FORM_DWORD_IND, FORM_DWORD_IND_DISP:
      begin
        // Ordinary range must align to four byte registers.
        sel.idx = num;
        sel.width = W_DWORD;
        sel.legal = ((num[1:0] == 2'b00) && (num <= DWORD_MAX))
          || (num == DWORD_ALT0) || (num == DWORD_ALT1);
      end
      default:
      begin
        sel.legal = 1'b1;
      end
    endcase
  end
endmodule // oad_reg_decode
`default_nettype wire

//--- oad_decoder.sv
// Operand address decoder: resolves operand notations per state time.
`timescale 1ns/1ps
`default_nettype none
module oad_decoder
  import oad_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic reqValid,
  input wire oad_req_t req,
  output logic reqReady,
  output logic resValid,
  output oad_res_t res
);
  // Width of the state time counter.
  localparam int CNT_W = (STATE_CLKS > 2) ? $clog2(STATE_CLKS) : 1;

  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } oad_state_t;

  // Whole state of this module.
  typedef struct packed {
    oad_state_t st;
    logic [CNT_W-1:0] cnt;
    logic ready;
    logic done;
    oad_res_t res;
  } oad_ctx_t;

  // Registered state and its next value.
  oad_ctx_t s_q;
  oad_ctx_t s_d;
  // Register selection for the incoming request.
  oad_rsel_t rsel;
  // Operand resolved from the incoming request.
  oad_res_t dec;
  // Sign-extended forms of the low field bytes.
  logic [23:0] relExt;
  logic [23:0] dispExt;
  // Low byte of a direct or bit operand.
  logic [7:0] lowByte;

  // Register index decode lives in its own small module.
  oad_reg_decode u_regs (
    .form(req.form),
    .field(req.field),
    .bank(req.bank),
    .sel(rsel)
  );

  // Sign extension keeps backward reach without a subtractor.
  assign relExt = {{16{req.field[7]}}, req.field[7:0]};
  assign dispExt = {{8{req.field[15]}}, req.field[15:0]};
  assign lowByte = req.field[7:0];

  // Operand resolution for the request now on the port.
  always_comb
  begin
    dec = '0;
    dec.space = SP_NONE;
    dec.width = W_BYTE;
    dec.regIdx = rsel.idx;
    unique case (req.form)
      FORM_DIRECT_BYTE:
      begin
        // Upper half of the byte space is SFR space.
        dec.space = (lowByte < SFR_BASE) ? SP_RAM : SP_SFR;
        dec.addr = {16'h0000, lowByte};
        // Width taken from the other operand of the instruction.
        dec.width = req.peerWidth;
      end
      FORM_DIRECT_WIDE:
      begin
        // Only the first 64 Kbytes are reachable this way.
        dec.space = SP_DATA;
        dec.addr = {REGION_ZERO, req.field[15:0]};
        dec.width = req.peerWidth;
      end
      FORM_IMM8:
      begin
        dec.space = SP_CONST;
        dec.value = {24'h000000, lowByte};
      end
      FORM_IMMEDIATE_WORD:
      begin
        dec.space = SP_CONST;
        dec.value = {16'h0000, req.field[15:0]};
        dec.width = W_WORD;
      end
      FORM_IMM_ZERO_EXT:
      begin
        dec.space = SP_CONST;
        dec.value = {16'h0000, req.field[15:0]};
        dec.width = W_DWORD;
      end
      FORM_IMM_ONE_EXT:
      begin
        dec.space = SP_CONST;
        dec.value = {16'hffff, req.field[15:0]};
        dec.width = W_DWORD;
      end
      FORM_SHORT:
      begin
        // Code three has no meaning and is flagged.
        dec.space = SP_CONST;
        dec.width = req.peerWidth;
        unique case (req.field[1:0])
          2'b00: dec.value = SHORT_ONE;
          2'b01: dec.value = SHORT_TWO;
          2'b10: dec.value = SHORT_FOUR;
          2'b11: dec.illegal = 1'b1;
        endcase
      end
      FORM_LEGACY_BIT:
      begin
        dec.bitOp = 1'b1;
        dec.bitPos = lowByte[2:0];
        if (lowByte < SFR_BASE)
        begin
          // Sixteen RAM bytes hold the lower 128 bits.
          dec.space = SP_RAM;
          dec.addr = {16'h0000, BIT_RAM_BASE + {4'h0, lowByte[6:3]}};
        end
        else
        begin
          // Only SFRs on an eight-byte boundary are bit capable.
          dec.space = SP_SFR;
          dec.addr = {16'h0000, lowByte[7:3], 3'b000};
        end
      end
      FORM_EXT_BIT:
      begin
        // Bytes below the bit window cannot be bit addressed.
        dec.bitOp = 1'b1;
        dec.bitPos = req.field[EXT_BIT_LSB +: 3];
        dec.addr = {REGION_ZERO, 8'h00, lowByte};
        dec.space = (lowByte < SFR_BASE) ? SP_RAM : SP_SFR;
        dec.illegal = (lowByte < EXT_BIT_LOW);
      end
      FORM_REL:
      begin
        // Wraps modulo the 24-bit space like the program counter.
        dec.space = SP_CODE;
        dec.addr = req.nextPc + relExt;
      end
      FORM_BLOCK_JUMP:
      begin
        dec.space = SP_CODE;
        dec.addr = {req.nextPc[23:11], req.field[10:0]};
      end
      FORM_REGION_JUMP:
      begin
        dec.space = SP_CODE;
        dec.addr = {req.nextPc[23:16], req.field[15:0]};
      end
      FORM_LINEAR_JUMP:
      begin
        dec.space = SP_CODE;
        dec.addr = req.field;
      end
      FORM_LEGACY_IND:
      begin
        // Pointer byte comes from R0 or R1 read by the pipeline.
        dec.space = SP_RAM;
        dec.addr = {16'h0000, req.ptr[7:0]};
        dec.width = req.peerWidth;
      end
      FORM_BANK_BYTE, FORM_FILE_BYTE:
      begin
        dec.space = SP_REG;
      end
      FORM_WORD_REG:
      begin
        dec.space = SP_REG;
        dec.width = W_WORD;
        dec.illegal = !rsel.legal;
      end
      FORM_WORD_IND:
      begin
        // The same address serves a jump through the register.
        dec.space = SP_DATA;
        dec.addr = {REGION_ZERO, req.ptr[15:0]};
        dec.width = req.peerWidth;
        dec.illegal = !rsel.legal;
      end
      FORM_WORD_IND_DISP:
      begin
        // The sum wraps within region zero.
        dec.space = SP_DATA;
        dec.addr = {REGION_ZERO, req.ptr[15:0] + req.field[15:0]};
        dec.width = req.peerWidth;
        dec.illegal = !rsel.legal;
      end
      FORM_DWORD_REG:
      begin
        dec.space = SP_REG;
        dec.width = W_DWORD;
        dec.illegal = !rsel.legal;
      end
      FORM_DWORD_IND:
      begin
        dec.space = SP_DATA;
        dec.addr = req.ptr[23:0];
        dec.width = req.peerWidth;
        dec.illegal = !rsel.legal;
      end
      FORM_DWORD_IND_DISP:
      begin
        dec.space = SP_DATA;
        dec.addr = req.ptr[23:0] + dispExt;
        dec.width = req.peerWidth;
        dec.illegal = !rsel.legal;
      end
      default:
      begin
        // Unused form codes are reported, never guessed at.
        dec.illegal = 1'b1;
      end
    endcase
  end

  // Sequencer: a request occupies one full state time.
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (reqValid)
        begin
          // Capture the result now; it is released at state end.
          s_d.res = dec;
          s_d.st = ST_BUSY;
          s_d.cnt = '0;
          s_d.ready = 1'b0;
        end
      end
      ST_BUSY:
      begin
        if (s_q.cnt == CNT_W'(STATE_CLKS - 2))
        begin
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
          s_d.ready = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      default:
      begin
        // A corrupted one-hot code falls back to idle.
        s_d.st = ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.st <= ST_IDLE;
      s_q.cnt <= '0;
      s_q.ready <= 1'b1;
      s_q.done <= 1'b0;
      s_q.res <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign reqReady = s_q.ready;
  assign resValid = s_q.done;
  assign res = s_q.res;
endmodule // oad_decoder
`default_nettype wire

//--- oad_decoder_props.sv
// Concurrent checks on the operand decoder ports.
`timescale 1ns/1ps
`default_nettype none
module oad_decoder_props
  import oad_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic reqValid,
  input wire oad_req_t req,
  input wire logic reqReady,
  input wire logic resValid,
  input wire oad_res_t res
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // High on the edge that takes a request.
  logic take;
  // Request held from its take, so each answer is judged against its cause.
  oad_req_t q;
  assign take = ce && reqValid && reqReady;
  // Capture the request at the take.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else if (take)
      q <= req;
  end
  property p_busy; take |=> !reqReady; endproperty
  a_busy: assert property (p_busy) else $error("ready right after take");
  property p_lat; take ##1 ce |=> resValid; endproperty
  a_lat: assert property (p_lat) else $error("answer not after one state");
  property p_pulse; resValid && ce |=> !resValid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
  property p_space; resValid && q.form == FORM_DIRECT_BYTE |->
    res.space == (q.field[7:0] < SFR_BASE ? SP_RAM : SP_SFR); endproperty
  a_space: assert property (p_space) else $error("direct byte space");
  property p_width; resValid && q.form == FORM_DIRECT_BYTE |-> res.width == q.peerWidth; endproperty
  a_width: assert property (p_width) else $error("direct byte width");
  property p_wide; resValid && q.form == FORM_DIRECT_WIDE |->
    res.addr == {REGION_ZERO, q.field[15:0]}; endproperty
  a_wide: assert property (p_wide) else $error("direct wide address");
  property p_rel; resValid && q.form == FORM_REL |->
    res.addr == q.nextPc + {{16{q.field[7]}}, q.field[7:0]}; endproperty
  a_rel: assert property (p_rel) else $error("relative target");
  property p_blk; resValid && q.form == FORM_BLOCK_JUMP |->
    res.addr == {q.nextPc[23:11], q.field[10:0]}; endproperty
  a_blk: assert property (p_blk) else $error("block target");
  property p_short; resValid && q.form == FORM_SHORT && q.field[1:0] != 2'h3 |->
    res.value == (32'h00000001 << q.field[1:0]); endproperty
  a_short: assert property (p_short) else $error("short constant");
endmodule // oad_decoder_props
`default_nettype wire

//--- oad_pipe_model.sv
// Behavioural pipeline model that presents requests to the decoder.
`timescale 1ns/1ps
`default_nettype none
module oad_pipe_model
  import oad_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire oad_req_t nx,
  input wire logic reqReady,
  output logic reqValid,
  output oad_req_t req
);
  // Set on the edge that took the request.
  logic taken = 1'b0;
  initial reqValid = 1'b0;
  initial req = '0;
  // Note the take so the request is only released after it.
  always @(posedge mclk)
  begin
    taken <= reqValid && reqReady;
  end
  // Hold until taken; then show the inverse so stale data never looks valid.
  always @(negedge mclk)
  begin
    if (go)
    begin
      reqValid <= 1'b1;
      req <= nx;
    end
    else if (taken)
    begin
      reqValid <= 1'b0;
      req <= ~req;
    end
  end
endmodule // oad_pipe_model
`default_nettype wire

//--- oad_decoder_tb.sv
// Self-checking testbench for the operand address decoder.
`timescale 1ns/1ps
`default_nettype none
module oad_decoder_tb
  import oad_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  // Request handed to the pipeline model and its launch strobe.
  logic go = 1'b0;
  oad_req_t nx = '0;
  logic reqValid;
  oad_req_t req;
  logic reqReady;
  logic resValid;
  oad_res_t res;
  int failures = 0;
  int n_checks = 0;
  // The 40 MHz clock.
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  // Clock enable is tied high; freezing is not exercised here.
  oad_decoder oad_decoder_i (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .resValid(resValid), .res(res));
  oad_pipe_model oad_pipe_model_i (.mclk(mclk), .go(go), .nx(nx), .reqReady(reqReady),
    .reqValid(reqValid), .req(req));
  // Print the counts and the verdict, then stop.
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ca(input logic [23:0] e);
    chk("addr", {8'h00, res.addr}, {8'h00, e});
  endtask
  task automatic cv(input logic [31:0] e);
    chk("value", res.value, e);
  endtask
  task automatic ci(input logic e);
    chk("illegal", {31'h0, res.illegal}, {31'h0, e});
  endtask
  task automatic cr(input logic [5:0] e);
    chk("regIdx", {26'h0, res.regIdx}, {26'h0, e});
  endtask
  task automatic cb(input logic [2:0] e);
    chk("bitPos", {29'h0, res.bitPos}, {29'h0, e});
  endtask
  // Issue one request and wait, bounded, for its answer pulse.
  task automatic run(input oad_form_t f, input logic [23:0] fld, input logic [23:0] pc = 24'h0,
    input logic [31:0] p = 32'h0, input logic [1:0] bk = 2'h0, input oad_width_t pw = W_BYTE);
    int i;
    logic seen;
    seen = 1'b0;
    @(negedge mclk);
    nx <= '{form: f, field: fld, nextPc: pc, ptr: p, bank: bk, peerWidth: pw};
    go <= 1'b1;
    @(negedge mclk);
    go <= 1'b0;
    for (i = 0; i < 8 && !seen; i++)
    begin
      @(posedge mclk);
      #1;
      seen = (resValid === 1'b1);
    end
    if (!seen)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  // Register index request with its expected legality.
  task automatic rl(input oad_form_t f, input logic [5:0] x, input logic bad);
    run(f, {18'h0, x});
    ci(bad);
    if (!bad)
      cr(x);
  endtask
  // Direct operands at the RAM/SFR boundary.
  task automatic t_direct;
    run(FORM_DIRECT_BYTE, 24'h00007f, 24'h0, 32'h0, 2'h0, W_WORD);
    chk("space", {29'h0, res.space}, {29'h0, SP_RAM});
    chk("width", {30'h0, res.width}, {30'h0, W_WORD});
    run(FORM_DIRECT_BYTE, 24'h000080, 24'h0, 32'h0, 2'h0, W_DWORD);
    chk("space", {29'h0, res.space}, {29'h0, SP_SFR});
    chk("width", {30'h0, res.width}, {30'h0, W_DWORD});
    run(FORM_DIRECT_WIDE, 24'h12beef);
    ca(24'h00beef);
  endtask
  // Every immediate form, including the refused short code.
  task automatic t_imm;
    int k;
    run(FORM_IMM8, 24'h1234a5);
    cv(32'h000000a5);
    run(FORM_IMMEDIATE_WORD, 24'hab8001);
    cv(32'h00008001);
    run(FORM_IMM_ZERO_EXT, 24'hab8001);
    cv(32'h00008001);
    run(FORM_IMM_ONE_EXT, 24'hab8001);
    cv(32'hffff8001);
    for (k = 0; k < 4; k++)
    begin
      run(FORM_SHORT, {22'h0, k[1:0]});
      ci(k == 3);
      if (k < 3)
        cv(32'h00000001 << k);
    end
  endtask
  // Bit forms at the edges of both halves and of the extended window.
  task automatic t_bits;
    run(FORM_LEGACY_BIT, 24'h00007f);
    ca(24'h00002f);
    cb(3'h7);
    run(FORM_LEGACY_BIT, 24'h00008b);
    ca(24'h000088);
    cb(3'h3);
    chk("bitOp", {31'h0, res.bitOp}, 32'h00000001);
    run(FORM_EXT_BIT, 24'h00051f);
    ci(1'b1);
    run(FORM_EXT_BIT, 24'h00067f);
    ci(1'b0);
    ca(24'h00007f);
    cb(3'h6);
    chk("bitOp", {31'h0, res.bitOp}, 32'h00000001);
  endtask
  // Control transfer targets crossing block and region edges.
  task automatic t_jump;
    run(FORM_REL, 24'h000080, 24'h010005);
    ca(24'h00ff85);
    run(FORM_REL, 24'h00007f, 24'h01fff0);
    ca(24'h02006f);
    run(FORM_BLOCK_JUMP, 24'hfff123, 24'h12f805);
    ca(24'h12f923);
    run(FORM_REGION_JUMP, 24'hab1234, 24'h07ffff);
    ca(24'h071234);
    run(FORM_LINEAR_JUMP, 24'hfedcba, 24'h010000);
    ca(24'hfedcba);
  endtask
  // Register selections, legal and refused.
  task automatic t_regs;
    run(FORM_LEGACY_IND, 24'h000001, 24'h0, 32'h1234c3);
    ca(24'h0000c3);
    cr(6'h01);
    run(FORM_BANK_BYTE, 24'h0000ff, 24'h0, 32'h0, 2'h3);
    cr(6'h1f);
    run(FORM_FILE_BYTE, 24'h00002f);
    cr(6'h0f);
    rl(FORM_WORD_REG, 6'h1e, 1'b0);
    rl(FORM_WORD_REG, 6'h1d, 1'b1);
    rl(FORM_WORD_REG, 6'h20, 1'b1);
    rl(FORM_DWORD_REG, 6'h1c, 1'b0);
    rl(FORM_DWORD_REG, 6'h1a, 1'b1);
    rl(FORM_DWORD_REG, 6'h38, 1'b0);
    rl(FORM_DWORD_REG, 6'h3c, 1'b0);
    rl(FORM_DWORD_REG, 6'h20, 1'b1);
  endtask
  // Indirect addressing with and without displacement, at wrap points.
  task automatic t_ind;
    run(FORM_WORD_IND, 24'h000002, 24'h0, 32'hab123456);
    ca(24'h003456);
    run(FORM_WORD_IND_DISP, 24'h000020, 24'h0, 32'h0000fff0);
    ca(24'h000010);
    run(FORM_DWORD_IND, 24'h000004, 24'h0, 32'h00ff1234);
    ca(24'hff1234);
    run(FORM_DWORD_IND_DISP, 24'h00fffe, 24'h0, 32'h00120000);
    ca(24'h11fffe);
  endtask
  // Reset, then every scenario in turn.
  initial
  begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    t_direct();
    t_imm();
    t_bits();
    t_jump();
    t_regs();
    t_ind();
    report_and_stop();
  end
endmodule // oad_decoder_tb
bind oad_decoder oad_decoder_props oad_decoder_props_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
  .reqValid(reqValid), .req(req), .reqReady(reqReady), .resValid(resValid), .res(res));
`default_nettype wire
